// >>> src/prs_core_reset.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - pin reset counts only after three low cycles; aborts and zeroes the pc
// - first fetch after reset is from program address zero
// - saturate mode, test flag and interrupt mask survive a pin reset
// - aux pointer, its backup and data page pointer survive a pin reset
// - sixteen-bit program counter with eight-entry return stack
// - direct and accumulator calls push the pc before jumping
// - subroutine exit pops top entry into the pc, rest move up
// - thirty-two word data ram at data address 60 hex, writable
// - taking an interrupt sets global disable and pushes return; a trap only pushes
// - pin reset loads countdown and period registers with all ones
module prs_core_reset
  import prs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic activeLowResetInput_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] fetchAddr,
  output logic coreInReset
);
  logic rsMeta_r, rsSync_r;
  logic [1:0] lowCnt_r;
  logic [15:0] pc_r;
  logic [15:0] acc_r;
  logic [15:0] countdownValue_r, reloadPeriod_r;
  logic overflowSaturateMode_r, testControlFlag_r, globalIrqDisable_r;
  logic [5:0] interruptMaskBits_r;
  logic [2:0] auxPointer_r, auxPointerBackup_r;
  logic [8:0] dataPagePointer_r;
  logic [15:0] smallRamBlock [PRS_RAM_WORDS];
  logic [31:0] prdata_r;

  // ==========================================================
  // reset pin synchroniser and qualifier
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rsMeta_r <= 1'b1;
      rsSync_r <= 1'b1;
    end
    else
    begin
      rsMeta_r <= activeLowResetInput_n;
      rsSync_r <= rsMeta_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset || rsSync_r)
      lowCnt_r <= 2'h0;
    else if (lowCnt_r != PRS_RST_CYCLES)
      lowCnt_r <= lowCnt_r + 2'h1;
  end

  wire pinReset = (lowCnt_r == PRS_RST_CYCLES);
  wire anyReset = reset || pinReset;

  // ==========================================================
  // apb decode
  wire setup = psel && !penable;
  wire wrEn = psel && penable && pwrite;
  wire ramHit = paddr[11:7] == PRS_RAM_BASE[11:7];
  wire [4:0] ramIdx = paddr[6:2];
  wire regHit = paddr <= PRS_TOS_OFS && paddr[1:0] == 2'b00;
  wire hit = ramHit || regHit;
  wire wrCmd = wrEn && paddr == PRS_CMD_OFS && !pinReset;
  wire wrMode = wrEn && paddr == PRS_MODE_OFS;
  wire wrImr = wrEn && paddr == PRS_IMR_OFS;
  wire wrAcc = wrEn && paddr == PRS_ACC_OFS;
  wire wrTim = wrEn && paddr == PRS_TIM_OFS;
  wire wrPrd = wrEn && paddr == PRS_PRD_OFS;
  wire wrRam = wrEn && ramHit;
  wire [2:0] opRaw = pwdata[PRS_OP_LSB +: 3];
  wire [15:0] target = pwdata[PRS_TGT_LSB +: 16];

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ==========================================================
  // program counter and return stack
  wire opStep = wrCmd && opRaw == PRS_OP_STEP;
  wire opCall = wrCmd && opRaw == PRS_OP_CALL;
  wire opCala = wrCmd && opRaw == PRS_OP_ACCUMULATOR_SUBROUTINE_JUMP;
  wire opRet = wrCmd && opRaw == PRS_OP_RET;
  wire opTrap = wrCmd && opRaw == PRS_OP_TRAP;
  wire opIrq = wrCmd && opRaw == PRS_OP_IRQ;
  wire doPush = opCall || opCala || opTrap || opIrq;
  wire [15:0] stackTop;
  wire [3:0] stackDepth;

  prs_pc_stack u_stack
  (
    .clk(clk),
    .reset(reset),
    .push(doPush),
    .pop(opRet),
    .pushData(pc_r),
    .topData(stackTop),
    .depth(stackDepth)
  );

  wire [15:0] pcNext = opStep ? pc_r + 16'h0001 :
                       opCall ? target :
                       opCala ? acc_r :
                       opRet ? stackTop :
                       opTrap ? PRS_TRAP_VEC :
                       opIrq ? target : pc_r;

  always_ff @(posedge clk)
  begin
    if (anyReset)
      pc_r <= PRS_PC_RST;
    else
      pc_r <= pcNext;
  end

  // ==========================================================
  // mode bits: only the clock reset clears them; either reset sets global disable
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      overflowSaturateMode_r <= 1'b0;
      testControlFlag_r <= 1'b0;
      auxPointer_r <= 3'h0;
      auxPointerBackup_r <= 3'h0;
      dataPagePointer_r <= 9'h000;
      interruptMaskBits_r <= 6'h00;
    end
    else
    begin
      if (wrMode)
      begin
        overflowSaturateMode_r <= pwdata[PRS_OVM_BIT];
        testControlFlag_r <= pwdata[PRS_TC_BIT];
        auxPointer_r <= pwdata[PRS_ARP_LSB +: 3];
        auxPointerBackup_r <= pwdata[PRS_ARB_LSB +: 3];
        dataPagePointer_r <= pwdata[PRS_DP_LSB +: 9];
      end
      if (wrImr)
        interruptMaskBits_r <= pwdata[5:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (anyReset || opIrq)
      globalIrqDisable_r <= 1'b1;
    else if (wrMode)
      globalIrqDisable_r <= pwdata[PRS_GLOBAL_IRQ_DISABLE_BIT];
  end

  // ==========================================================
  // accumulator, timer registers, ram block
  always_ff @(posedge clk)
  begin
    if (reset)
      acc_r <= 16'h0000;
    else if (wrAcc)
      acc_r <= pwdata[15:0];
  end

  always_ff @(posedge clk)
  begin
    if (anyReset)
    begin
      countdownValue_r <= PRS_TMR_RST;
      reloadPeriod_r <= PRS_TMR_RST;
    end
    else
    begin
      if (wrTim)
        countdownValue_r <= pwdata[15:0];
      if (wrPrd)
        reloadPeriod_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (wrRam)
      smallRamBlock[ramIdx] <= pwdata[15:0];
  end

  // ==========================================================
  // read mux, registered in the setup phase
  wire [31:0] modeWord = {7'h00, dataPagePointer_r, 5'h00, auxPointerBackup_r,
                          1'b0, auxPointer_r, 1'b0, globalIrqDisable_r,
                          testControlFlag_r, overflowSaturateMode_r};
  wire [31:0] statWord = {27'h0, pinReset, stackDepth};
  wire [31:0] rdMux = ramHit ? {16'h0000, smallRamBlock[ramIdx]} :
                      paddr == PRS_PC_OFS ? {16'h0000, pc_r} :
                      paddr == PRS_STAT_OFS ? statWord :
                      paddr == PRS_MODE_OFS ? modeWord :
                      paddr == PRS_IMR_OFS ? {26'h0, interruptMaskBits_r} :
                      paddr == PRS_ACC_OFS ? {16'h0000, acc_r} :
                      paddr == PRS_TIM_OFS ? {16'h0000, countdownValue_r} :
                      paddr == PRS_PRD_OFS ? {16'h0000, reloadPeriod_r} :
                      paddr == PRS_TOS_OFS ? {16'h0000, stackTop} : 32'h00000000;

  always_ff @(posedge clk)
  begin
    if (reset)
      prdata_r <= 32'h00000000;
    else if (setup)
      prdata_r <= rdMux;
  end

  assign prdata = prdata_r;
  assign fetchAddr = pc_r;
  assign coreInReset = pinReset;
endmodule : prs_core_reset
`default_nettype wire

// >>> src/prs_pc_stack.sv
`timescale 1ns/100ps
`default_nettype none
module prs_pc_stack
  import prs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic push,
  input wire logic pop,
  input wire logic [15:0] pushData,
  output logic [15:0] topData,
  output logic [3:0] depth
);
  logic [15:0] stk_r [PRS_STACK_DEPTH];
  logic [3:0] depth_r;

  // ==========================================================
  // eight-level return stack
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      stk_r[0] <= pushData;
      for (int i = 1; i < PRS_STACK_DEPTH; i++)
        stk_r[i] <= stk_r[i-1];
    end
    else if (pop)
    begin
      for (int i = 0; i < PRS_STACK_DEPTH - 1; i++)
        stk_r[i] <= stk_r[i+1];
      stk_r[PRS_STACK_DEPTH-1] <= stk_r[PRS_STACK_DEPTH-1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      depth_r <= 4'h0;
    else if (push && depth_r != 4'h8)
      depth_r <= depth_r + 4'h1;
    else if (pop && depth_r != 4'h0)
      depth_r <= depth_r - 4'h1;
  end

  assign topData = stk_r[0];
  assign depth = depth_r;
endmodule : prs_pc_stack
`default_nettype wire

// >>> src/prs_pkg.sv
package prs_pkg;
  // apb byte offsets
  localparam logic [11:0] PRS_CMD_OFS = 12'h000;
  localparam logic [11:0] PRS_PC_OFS = 12'h004;
  localparam logic [11:0] PRS_STAT_OFS = 12'h008;
  localparam logic [11:0] PRS_MODE_OFS = 12'h00C;
  localparam logic [11:0] PRS_IMR_OFS = 12'h010;
  localparam logic [11:0] PRS_ACC_OFS = 12'h014;
  localparam logic [11:0] PRS_TIM_OFS = 12'h018;
  localparam logic [11:0] PRS_PRD_OFS = 12'h01C;
  localparam logic [11:0] PRS_TOS_OFS = 12'h020;
  // small ram block: data word index and its byte window
  localparam logic [9:0] PRS_RAM_IDX = 10'h060;
  localparam int PRS_RAM_WORDS = 32;
  localparam logic [11:0] PRS_RAM_BASE = {PRS_RAM_IDX, 2'b00};
  // command field
  localparam int PRS_OP_LSB = 0;
  localparam int PRS_TGT_LSB = 16;
  // mode register fields
  localparam int PRS_OVM_BIT = 0;
  localparam int PRS_TC_BIT = 1;
  localparam int PRS_GLOBAL_IRQ_DISABLE_BIT = 2;
  localparam int PRS_ARP_LSB = 4;
  localparam int PRS_ARB_LSB = 8;
  localparam int PRS_DP_LSB = 16;
  // status fields
  localparam int PRS_DEPTH_LSB = 0;
  localparam int PRS_INRST_BIT = 4;
  // reset values and timing
  localparam logic [15:0] PRS_PC_RST = 16'h0000;
  localparam logic [15:0] PRS_TMR_RST = 16'hFFFF;
  localparam logic [15:0] PRS_TRAP_VEC = 16'h001E;
  localparam logic [1:0] PRS_RST_CYCLES = 2'h3;
  localparam int PRS_STACK_DEPTH = 8;
  typedef enum logic [2:0]
  {
    PRS_OP_NONE,
    PRS_OP_STEP,
    PRS_OP_CALL,
    PRS_OP_ACCUMULATOR_SUBROUTINE_JUMP,
    PRS_OP_RET,
    PRS_OP_TRAP,
    PRS_OP_IRQ
  } prs_op_e;
endpackage : prs_pkg

// >>> tb/prs_core_reset_bench.sv
`timescale 1ns/100ps
`default_nettype none
module prs_core_reset_bench
  import prs_pkg::*;
;
  logic clk = 0, reset = 1, activeLowResetInput_n = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rnd = 32'hD8FC, mode, ram[32], expQ[$];
  logic [15:0] stk[8], pc, t;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, coreInReset;
  wire logic [15:0] fetchAddr;
  int fails = 0, compares = 0;
  prs_core_reset dut (.clk, .reset, .activeLowResetInput_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .fetchAddr, .coreInReset);
  initial
  begin
    forever #50 clk = ~clk;
  end
  function logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction : xs
  task chk(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk(expQ.pop_front(), prdata);
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 0;
    penable <= 0;
  endtask : xfer
  task rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd
  task op(input logic [2:0] o, input logic [15:0] d);
    // accumulator call carries a wrong target so only the accumulator can steer it
    xfer(1'b1, PRS_CMD_OFS, {o == 3'h3 ? ~d : d, 13'h0, o});
    if (o == 3'h1)
      pc = pc + 16'h1;
    else if (o == 3'h4)
    begin
      pc = stk[0];
      for (int i = 0; i < 7; i++)
        stk[i] = stk[i + 1];
    end
    else
    begin
      for (int i = 7; i > 0; i--)
        stk[i] = stk[i - 1];
      stk[0] = pc;
      pc = (o == 3'h5) ? PRS_TRAP_VEC : d;
      if (o == 3'h6)
        mode[PRS_GLOBAL_IRQ_DISABLE_BIT] = 1'b1;
    end
  endtask : op
  task pin(input int n);
    @(posedge clk);
    activeLowResetInput_n <= 0;
    repeat (n) @(posedge clk);
  endtask : pin
  task give_verdict();
    if (expQ.size() != 0)
      fails++;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 0;
    pc = 16'h0;
    rd(PRS_PC_OFS, 32'h0);
    rd(PRS_PRD_OFS, 32'hFFFF);
    mode = xs() & 32'h01FF0773;
    xfer(1'b1, PRS_MODE_OFS, mode);
    xfer(1'b1, PRS_IMR_OFS, 32'h2A);
    xfer(1'b1, PRS_TIM_OFS, 32'h1234);
    xfer(1'b1, PRS_PRD_OFS, 32'h5678);
    op(3'h1, 16'h0);
    for (int i = 0; i < 9; i++)
    begin
      t = 16'(xs());
      xfer(1'b1, PRS_ACC_OFS, {16'h0, t});
      op(i[0] ? 3'h3 : 3'h2, t);
      rd(PRS_TOS_OFS, {16'h0, stk[0]});
    end
    rd(PRS_STAT_OFS, 32'h8);
    for (int i = 0; i < 9; i++)
    begin
      op(3'h4, 16'h0);
      rd(PRS_PC_OFS, {16'h0, pc});
    end
    op(3'h5, 16'h0);
    op(3'h6, 16'(xs()));
    rd(PRS_TOS_OFS, {16'h0, stk[0]});
    rd(PRS_MODE_OFS, mode);
    for (int i = 0; i < 32; i++)
    begin
      ram[i] = xs();
      xfer(1'b1, PRS_RAM_BASE + 12'(4 * i), ram[i]);
    end
    rd(12'h100, 32'h0);
    pin(2);
    activeLowResetInput_n <= 1;
    rd(PRS_PC_OFS, {16'h0, pc});
    pin(8);
    // in reset, with the trap and interrupt entries still stacked
    rd(PRS_STAT_OFS, 32'h12);
    xfer(1'b1, PRS_CMD_OFS, 32'h1);
    rd(PRS_PC_OFS, 32'h0);
    activeLowResetInput_n <= 1;
    repeat (6) @(posedge clk);
    mode[PRS_GLOBAL_IRQ_DISABLE_BIT] = 1'b1;
    rd(PRS_PC_OFS, 32'h0);
    rd(PRS_MODE_OFS, mode);
    rd(PRS_IMR_OFS, 32'h2A);
    rd(PRS_TIM_OFS, 32'hFFFF);
    rd(PRS_PRD_OFS, 32'hFFFF);
    for (int i = 0; i < 32; i++)
      rd(PRS_RAM_BASE + 12'(4 * i), ram[i] & 32'hFFFF);
    // let the monitor take the last read before ending
    @(posedge clk);
    give_verdict();
  end
endmodule : prs_core_reset_bench
bind prs_core_reset prs_core_reset_checker chk (.clk, .reset, .activeLowResetInput_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fetchAddr, .coreInReset);
`default_nettype wire

// >>> tb/prs_core_reset_checker.sv
`timescale 1ns/100ps
`default_nettype none
module prs_core_reset_checker
  import prs_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic activeLowResetInput_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] fetchAddr,
  input wire logic coreInReset
);
  // ==========
  // decode
  wire logic accW = psel && penable;
  wire logic cmdW = accW && pwrite && paddr == PRS_CMD_OFS && !coreInReset;
  wire logic [2:0] opW = pwdata[2:0];
  wire logic [15:0] tgtW = pwdata[31:16];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // checks
  property p_ready; accW |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_hole; accW && paddr > PRS_TOS_OFS && paddr < PRS_RAM_BASE |-> pslverr; endproperty
  a_hole: assert property (p_hole) else $error("no error on hole");
  property p_qual; $rose(coreInReset) |-> !$past(activeLowResetInput_n, 3)
    && !$past(activeLowResetInput_n, 4); endproperty
  a_qual: assert property (p_qual) else $error("reset too early");
  property p_held; coreInReset && $past(coreInReset) |-> fetchAddr == PRS_PC_RST; endproperty
  a_held: assert property (p_held) else $error("pc not zero");
  property p_first; $fell(coreInReset) |-> fetchAddr == PRS_PC_RST; endproperty
  a_first: assert property (p_first) else $error("first fetch");
  property p_step; cmdW && opW == 3'h1 |=> fetchAddr == $past(fetchAddr) + 16'h1; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_call; cmdW && opW == 3'h2 |=> fetchAddr == $past(tgtW); endproperty
  a_call: assert property (p_call) else $error("call");
  property p_irq; cmdW && opW == 3'h6 |=> fetchAddr == $past(tgtW); endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_trap; cmdW && opW == 3'h5 |=> fetchAddr == PRS_TRAP_VEC; endproperty
  a_trap: assert property (p_trap) else $error("trap");
  property p_stay; !coreInReset && !cmdW |=> fetchAddr == $past(fetchAddr); endproperty
  a_stay: assert property (p_stay) else $error("pc moved");
  property p_rst; $rose(coreInReset) |=> fetchAddr == PRS_PC_RST; endproperty
  a_rst: assert property (p_rst) else $error("pc not forced");
endmodule : prs_core_reset_checker
`default_nettype wire
